// ==== design/fptr_rom.sv ====
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module fptr_rom #(
	parameter bit LOW_VOLTAGE = 1'b0 // one selects the 1.8v variant
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire fptr_pkg::fptr_apb_req_t apb_req,
	output fptr_pkg::fptr_apb_rsp_t apb_rsp,
	// serial pins to and from the host
	input wire logic ser_cs_n,
	input wire logic ser_sck,
	output fptr_pkg::fptr_ser_out_t ser_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic cs_s1; // cs sync first stage
		logic cs_s2; // cs sync second stage
		logic cs_s3; // cs previous sample
		logic sck_s1; // sck sync first stage
		logic sck_s2; // sck sync second stage
		logic sck_s3; // sck previous sample
		logic active; // frame in progress
		logic [4:0] cnt; // bit position in word
		logic [2:0] frame_sel; // word held for the frame
		logic so; // serial output bit
		logic [2:0] sel; // software word select
		logic [31:0] prdata; // apb read data
		logic pslverr; // apb error flag
	} fptr_state_t;

	localparam fptr_state_t ST_RST = '{
		cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
		sck_s1: 1'b0, sck_s2: 1'b0, sck_s3: 1'b0,
		active: 1'b0, cnt: 5'h00, frame_sel: fptr_pkg::SEL_RST,
		so: 1'b0, sel: fptr_pkg::SEL_RST,
		prdata: 32'h00000000, pslverr: 1'b0
	};

	fptr_state_t st_q; // registered state
	fptr_state_t st_d; // next state

	// ****************************************************************
	// table lookup
	// ****************************************************************
	// words are constants, so no write path reaches them
	localparam logic [31:0] W64 = LOW_VOLTAGE ? fptr_pkg::W64_1V8 : fptr_pkg::W64_3V;

	// word by select code, unused codes read all ones
	function automatic logic [31:0] word_of(input logic [2:0] s);
		logic [31:0] w;
		w = 32'hffffffff;
		case (s)
			3'h0: w = fptr_pkg::W58;
			3'h1: w = fptr_pkg::W5C;
			3'h2: w = fptr_pkg::W60;
			3'h3: w = W64;
			3'h4: w = fptr_pkg::W68;
			3'h5: w = fptr_pkg::W6C;
			default: w = 32'hffffffff;
		endcase
		return w;
	endfunction

	// bit order: byte 0 first, msb first within a byte
	function automatic logic bit_at(input logic [31:0] w, input logic [4:0] c);
		logic [4:0] idx;
		idx = {c[4:3], ~c[2:0]};
		return w[idx];
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	logic cs_fall; // frame start seen
	logic cs_rise; // frame end seen
	logic sck_fall; // host shift edge
	logic setup; // apb setup phase
	logic [4:0] cnt_nx; // incremented bit position

	always_comb begin
		st_d = st_q;
		// two flop synchronisers, third stage only for edges
		st_d.cs_s1 = ser_cs_n;
		st_d.cs_s2 = st_q.cs_s1;
		st_d.cs_s3 = st_q.cs_s2;
		st_d.sck_s1 = ser_sck;
		st_d.sck_s2 = st_q.sck_s1;
		st_d.sck_s3 = st_q.sck_s2;
		cs_fall = st_q.cs_s3 & ~st_q.cs_s2;
		cs_rise = ~st_q.cs_s3 & st_q.cs_s2;
		sck_fall = st_q.sck_s3 & ~st_q.sck_s2;
		cnt_nx = st_q.cnt + 5'h01;
		setup = apb_req.psel & ~apb_req.penable;
		// serial engine
		if (cs_rise) begin
			// chip enable high ends the repeat
			st_d.active = 1'b0;
			st_d.cnt = 5'h00;
		end else if (cs_fall) begin
			// latch select so a mid-frame write cannot tear a word
			st_d.active = 1'b1;
			st_d.frame_sel = st_q.sel;
			st_d.cnt = 5'h00;
			st_d.so = bit_at(word_of(st_q.sel), 5'h00);
		end else if (st_q.active && sck_fall) begin
			// count wraps, so the same word repeats
			st_d.cnt = cnt_nx;
			st_d.so = bit_at(word_of(st_q.frame_sel), cnt_nx);
		end
		// apb: decode in setup, answer in access
		if (setup) begin
			st_d.pslverr = 1'b0;
			st_d.prdata = 32'h00000000;
			case (apb_req.paddr)
				fptr_pkg::OFF_SEL: st_d.prdata = {29'h0, st_q.sel};
				fptr_pkg::OFF_STAT: st_d.prdata = {26'h0, st_q.cnt, st_q.active};
				fptr_pkg::OFF_W58: st_d.prdata = fptr_pkg::W58;
				fptr_pkg::OFF_W5C: st_d.prdata = fptr_pkg::W5C;
				fptr_pkg::OFF_W60: st_d.prdata = fptr_pkg::W60;
				fptr_pkg::OFF_W64: st_d.prdata = W64;
				fptr_pkg::OFF_W68: st_d.prdata = fptr_pkg::W68;
				fptr_pkg::OFF_W6C: st_d.prdata = fptr_pkg::W6C;
				default: st_d.pslverr = 1'b1;
			endcase
			// writes to table words are quietly dropped
			if (apb_req.pwrite) begin
				st_d.prdata = 32'h00000000;
			end
		end
		// select write lands at the access edge
		if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
			if (apb_req.paddr == fptr_pkg::OFF_SEL) begin
				// out-of-range codes are ignored
				if (apb_req.pwdata[2:0] <= fptr_pkg::SEL_LAST) begin
					st_d.sel = apb_req.pwdata[2:0];
				end
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// zero wait: setup already loaded prdata
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.prdata = st_q.prdata;
	assign apb_rsp.pslverr = st_q.pslverr & apb_req.penable;
	// drive the pin only inside a frame
	assign ser_out.so = st_q.so;
	assign ser_out.so_oe = st_q.active;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic rd_acc; // apb read access phase
	assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

	a_word58_value: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W58 |-> apb_rsp.prdata[30:0] == 31'h4801d882)
		else $error("word 58 wrong");
	a_word58_units: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W58 |-> apb_rsp.prdata[31:29] == 3'b110)
		else $error("word 58 units or reserved wrong");
	a_word5c_value: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W5C |-> apb_rsp.prdata == 32'h4c698dec)
		else $error("word 5c wrong");
	a_word60_value: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W60 |-> apb_rsp.prdata == 32'h757a757a)
		else $error("word 60 wrong");
	a_word64_opcodes: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W64
		|-> apb_rsp.prdata[30:15] == 16'hb9ab && apb_rsp.prdata[7:0] == 8'hf7)
		else $error("word 64 opcodes wrong");
	a_word64_wait: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W64
		|-> apb_rsp.prdata[14:8] == (LOW_VOLTAGE ? 7'b0100100 : 7'b0100010))
		else $error("word 64 wake wait wrong");
	a_word68_value: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W68 |-> apb_rsp.prdata == 32'hff2cc24a)
		else $error("word 68 wrong");
	a_word6c_value: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && apb_req.paddr == fptr_pkg::OFF_W6C |-> apb_rsp.prdata == 32'ha9fa30e8)
		else $error("word 6c wrong");
	a_repeat_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		st_q.active && st_q.cnt == fptr_pkg::BIT_LAST && sck_fall && !cs_rise
		|=> st_q.cnt == 5'h00 && st_q.active && ser_out.so == bit_at(word_of(st_q.frame_sel), 5'h00))
		else $error("word did not repeat");
	a_frame_end: assert property (@(posedge clk) disable iff (sys_rst)
		cs_rise |=> !ser_out.so_oe ##1 !ser_out.so_oe || $fell(st_q.cs_s2))
		else $error("output not released at frame end");
	a_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst)
		rd_acc && $past(setup) && apb_req.paddr == 8'h08 |-> apb_rsp.pslverr)
		else $error("unmapped read without error");

	// ****************************************************************
	// field checks
	// ****************************************************************
	// one strobe per table word except word 60 keeps each property short;
	// values below are typed in field by field, not copied from the words
	logic rd_w58; // read access to the program timing word
	logic rd_w5c; // read access to the suspend limits word
	logic rd_w64; // read access to the power-down word
	logic rd_w68; // read access to the quad mode word
	logic rd_w6c; // read access to the status write word
	logic wr_tbl; // aligned write access aimed at a table word
	logic wr_sel; // write access to the select register
	assign rd_w58 = rd_acc & (apb_req.paddr == fptr_pkg::OFF_W58);
	assign rd_w5c = rd_acc & (apb_req.paddr == fptr_pkg::OFF_W5C);
	assign rd_w64 = rd_acc & (apb_req.paddr == fptr_pkg::OFF_W64);
	assign rd_w68 = rd_acc & (apb_req.paddr == fptr_pkg::OFF_W68);
	assign rd_w6c = rd_acc & (apb_req.paddr == fptr_pkg::OFF_W6C);
	assign wr_tbl = apb_req.psel & apb_req.penable & apb_req.pwrite
		& (apb_req.paddr[1:0] == 2'b00)
		& (apb_req.paddr >= fptr_pkg::OFF_W58) & (apb_req.paddr <= fptr_pkg::OFF_W6C);
	assign wr_sel = apb_req.psel & apb_req.penable & apb_req.pwrite
		& (apb_req.paddr == fptr_pkg::OFF_SEL);
	// program timing word, one property per field except bits 7:4
	a_prog_mult: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w58 |-> apb_rsp.prdata[3:0] == 4'b0010)
		else $error("program multiplier wrong");
	a_page_time: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w58 |-> apb_rsp.prdata[13:8] == 6'b011000)
		else $error("page program time wrong");
	a_first_byte: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w58 |-> apb_rsp.prdata[18:14] == 5'b00111)
		else $error("first byte time wrong");
	a_extra_byte: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w58 |-> apb_rsp.prdata[23:19] == 5'b00000)
		else $error("additional byte time wrong");
	a_chip_erase: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w58 |-> apb_rsp.prdata[30:24] == 7'b1001000)
		else $error("chip erase time wrong");
	// suspend limits word
	a_prog_mask: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w5c |-> apb_rsp.prdata[3:0] == 4'b1100)
		else $error("program suspend mask wrong");
	a_erase_mask: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w5c |-> apb_rsp.prdata[7:4] == 4'b1110)
		else $error("erase suspend mask wrong");
	a_prog_gap: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w5c |-> apb_rsp.prdata[12:9] == 4'b0110)
		else $error("program resume gap wrong");
	a_prog_latency: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w5c |-> apb_rsp.prdata[19:13] == 7'b1001100)
		else $error("program suspend latency wrong");
	a_erase_gap: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w5c |-> apb_rsp.prdata[23:20] == 4'b0110)
		else $error("erase resume gap wrong");
	a_erase_latency: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w5c |-> apb_rsp.prdata[30:24] == 7'b1001100)
		else $error("erase suspend latency wrong");
	// polling and power-down word
	a_busy_poll: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w64 |-> apb_rsp.prdata[7:2] == 6'b111101)
		else $error("busy polling code wrong");
	a_sleep_opcode: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w64 |-> apb_rsp.prdata[30:23] == 8'hb9)
		else $error("power-down opcode wrong");
	// quad mode word
	a_quad_seq: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w68 |-> apb_rsp.prdata[8:0] == 9'b001001010)
		else $error("quad mode sequences wrong");
	a_cont_read: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w68 |-> apb_rsp.prdata[15:9] == 7'b1100001)
		else $error("continuous read leave wrong");
	a_cont_entry: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w68 |-> apb_rsp.prdata[19:16] == 4'b1100)
		else $error("continuous read entry wrong");
	a_quad_enable: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w68 |-> apb_rsp.prdata[23:20] == 4'b0010)
		else $error("quad enable requirement wrong");
	// status write and reset word
	a_status_write: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w6c |-> apb_rsp.prdata[6:0] == 7'b1101000)
		else $error("status write code wrong");
	a_reset_support: assert property (@(posedge clk) disable iff (sys_rst)
		rd_w6c |-> apb_rsp.prdata[13:8] == 6'b110000)
		else $error("reset support code wrong");
	// table words ignore writes and raise no error
	a_table_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_tbl |-> apb_rsp.prdata == 32'h00000000 && !apb_rsp.pslverr)
		else $error("table write answered wrongly");
	// select write takes legal codes only, so a frame never sees a hole
	a_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
		wr_sel && apb_req.pwdata[2:0] <= fptr_pkg::SEL_LAST
		|=> st_q.sel == $past(apb_req.pwdata[2:0]))
		else $error("select write lost");
	a_sel_refuse: assert property (@(posedge clk) disable iff (sys_rst)
		wr_sel && apb_req.pwdata[2:0] > fptr_pkg::SEL_LAST |=> $stable(st_q.sel))
		else $error("out-of-range select taken");
	// serial engine: frame start, word fixed and bit held between host edges; apb error only in access phase
	a_frame_start: assert property (@(posedge clk) disable iff (sys_rst)
		cs_fall |=> ser_out.so_oe && st_q.cnt == 5'h00)
		else $error("frame did not start");
	a_frame_word: assert property (@(posedge clk) disable iff (sys_rst)
		st_q.active && !cs_fall |=> $stable(st_q.frame_sel))
		else $error("word changed inside a frame");
	a_bit_hold: assert property (@(posedge clk) disable iff (sys_rst)
		st_q.active && !sck_fall && !cs_fall && !cs_rise
		|=> $stable(st_q.cnt) && $stable(ser_out.so))
		else $error("bit moved without a host edge");
	a_err_phase: assert property (@(posedge clk) disable iff (sys_rst)
		!apb_req.penable |-> !apb_rsp.pslverr)
		else $error("error outside access phase");

endmodule

// ==== pkg/fptr_pkg.sv ====
// ****************************************************************
// parameter table constants
// ****************************************************************
package fptr_pkg;
	// apb byte offsets
	localparam logic [7:0] OFF_SEL = 8'h00; // serial word select
	localparam logic [7:0] OFF_STAT = 8'h04; // serial engine state
	localparam logic [7:0] OFF_W58 = 8'h58; // program timing word
	localparam logic [7:0] OFF_W5C = 8'h5c; // suspend limits word
	localparam logic [7:0] OFF_W60 = 8'h60; // suspend opcodes word
	localparam logic [7:0] OFF_W64 = 8'h64; // polling and power-down word
	localparam logic [7:0] OFF_W68 = 8'h68; // quad mode word
	localparam logic [7:0] OFF_W6C = 8'h6c; // status write and reset word
	// word select codes and counts
	localparam logic [2:0] SEL_LAST = 3'h5; // highest valid select
	localparam logic [2:0] SEL_RST = 3'h0; // select after reset
	localparam logic [4:0] BIT_LAST = 5'h1f; // last bit of a word
	// fixed table words, reserved bits one
	localparam logic [31:0] W58 = {1'b1, 2'b10, 5'b01000, 1'b0, 4'b0000, 1'b0,
		4'b0111, 1'b0, 5'b11000, 4'b1000, 4'b0010};
	localparam logic [31:0] W5C = {1'b0, 2'b10, 5'b01100, 4'b0110, 2'b10,
		5'b01100, 4'b0110, 1'b1, 4'b1110, 4'b1100};
	localparam logic [31:0] W60 = 32'h757a757a;
	localparam logic [4:0] DPD_WAIT_3V = 5'b00010; // wake wait, 3v part
	localparam logic [4:0] DPD_WAIT_1V8 = 5'b00100; // wake wait, 1.8v part
	localparam logic [31:0] W64_3V = {1'b0, 8'hb9, 8'hab, 2'b01, DPD_WAIT_3V,
		6'b111101, 2'b11};
	localparam logic [31:0] W64_1V8 = {1'b0, 8'hb9, 8'hab, 2'b01, DPD_WAIT_1V8,
		6'b111101, 2'b11};
	localparam logic [31:0] W68 = {8'hff, 1'b0, 3'b010, 4'b1100, 6'b110000, 1'b1,
		5'b00100, 4'b1010};
	localparam logic [31:0] W6C = {8'b10101001, 10'b1111101000, 6'b110000, 1'b1,
		7'b1101000};
	// apb signal groups
	typedef struct packed {
		logic psel; // slave selected
		logic penable; // access phase
		logic pwrite; // write direction
		logic [7:0] paddr; // byte address
		logic [31:0] pwdata; // write data
	} fptr_apb_req_t;
	typedef struct packed {
		logic pready; // transfer done
		logic [31:0] prdata; // read data
		logic pslverr; // unmapped address
	} fptr_apb_rsp_t;
	// serial pin group
	typedef struct packed {
		logic so; // serial data out
		logic so_oe; // output enable
	} fptr_ser_out_t;
endpackage

// ==== test/fptr_host_model.sv ====
`timescale 1ns/1ns
// ****************************************************************
// host serial controller model
// ****************************************************************
module fptr_host_model (
	// clock and start
	input wire logic clk,
	input wire logic go,
	// device pins
	input wire fptr_pkg::fptr_ser_out_t ser_out,
	output logic cs_n,
	output logic sck,
	// two word times of received data
	output logic [63:0] rx,
	output logic done
);
	// one frame per go; sck idles low so no stray edges outside frames
	initial begin
		int k;
		cs_n = 1'b1;
		sck = 1'b0;
		done = 1'b0;
		rx = '0;
		forever begin
			@(posedge clk);
			done <= 1'b0;
			if (go) begin
				cs_n <= 1'b0;
				repeat (6) @(posedge clk);
				// 64 bits: bytes ascending, msb first, keeps clocking past one word
				for (k = 0; k < 64; k++) begin
					rx[32*(k/32)+8*((k%32)/8)+7-(k%8)] <= ser_out.so;
					sck <= 1'b1;
					// both phases well above the 3 clk minimum of the sync stage
					repeat (4) @(posedge clk);
					sck <= 1'b0;
					repeat (6) @(posedge clk);
				end
				cs_n <= 1'b1;
				done <= 1'b1;
			end
		end
	end
endmodule

// ==== test/tb_fptr_rom.sv ====
`timescale 1ns/1ns
// ****************************************************************
// parameter table bench
// ****************************************************************
module tb_fptr_rom;
	typedef struct packed {logic [32:0] e; logic [32:0] m;} fptr_note_t; // expect, mask
	logic clk, sys_rst, cs_n, sck, go, done; // bench drive
	fptr_pkg::fptr_apb_req_t req; // apb request
	fptr_pkg::fptr_apb_rsp_t rsp; // apb answer
	fptr_pkg::fptr_ser_out_t so; // serial pins
	logic [63:0] rx; // host capture
	logic [31:0] ew [6]; // expected table words
	logic [31:0] rnd = 32'h5bdae7b7; // xorshift state
	fptr_note_t apb_q [$]; // pending bus results
	logic [63:0] ser_q [$]; // pending frames
	int err_count = 0, cmp_count = 0, cyc = 0;
	fptr_rom u_fptr_rom (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
		.ser_cs_n(cs_n), .ser_sck(sck), .ser_out(so));
	fptr_host_model u_fptr_host_model (.clk(clk), .go(go), .ser_out(so), .cs_n(cs_n),
		.sck(sck), .rx(rx), .done(done));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic final_report();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_apb(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t apb got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_ser(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t ser got %h exp %h", $time, got, exp);
		end
	endtask
	// one transfer; the note is queued before setup, popped at completion
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		apb_q.push_back('{e, m});
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// watchers take results at the completing edge, before the design updates
	always @(posedge clk) begin
		fptr_note_t n;
		if (req.psel && req.penable && rsp.pready === 1'b1 && apb_q.size() > 0) begin
			n = apb_q.pop_front();
			chk_apb({rsp.pslverr, rsp.prdata} & n.m, n.e);
		end
		if (done && ser_q.size() > 0) chk_ser(rx, ser_q.pop_front());
	end
	// hang guard, well beyond six frames and the bus traffic
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		req = '0;
		go = 1'b0;
		sys_rst = 1'b1;
		ew[0] = {1'b1, 2'b10, 5'b01000, 1'b0, 4'b0000, 1'b0, 4'b0111, 1'b0, 5'b11000,
			4'b1000, 4'b0010};
		ew[1] = {1'b0, 2'b10, 5'b01100, 4'b0110, 2'b10, 5'b01100, 4'b0110, 1'b1,
			4'b1110, 4'b1100};
		ew[2] = 32'h757a757a;
		ew[3] = {1'b0, 8'hb9, 8'hab, 2'b01, 5'b00010, 6'b111101, 2'b11};
		ew[4] = {8'hff, 1'b0, 3'b010, 4'b1100, 6'b110000, 1'b1, 5'b00100,
			4'b1010};
		ew[5] = {8'ha9, 10'b1111101000, 6'b110000, 1'b1, 7'b1101000};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, 8'h08, 32'h0, 33'h1_0000_0000, '1); // unmapped gap
		apb(1'b0, 8'h70, 32'h0, 33'h1_0000_0000, '1); // unmapped past table
		for (int i = 0; i < 6; i++) begin
			rnd = xs(rnd);
			apb(1'b1, 8'h00, 32'(i), 33'h0, 33'h1_0000_0000);
			apb(1'b1, 8'h00, 32'h6 + 32'(rnd[0]), 33'h0, 33'h1_0000_0000); // select above 5
			apb(1'b0, 8'h00, 32'h0, 33'(i), 33'h1_0000_0007);
			apb(1'b1, 8'h58 + 8'(4 * i), rnd, 33'h0, 33'h1_0000_0000);
			apb(1'b0, 8'h58 + 8'(4 * i), 32'h0, {1'b0, ew[i]}, '1);
			ser_q.push_back({ew[i], ew[i]});
			@(posedge clk);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			wait (done === 1'b1);
			repeat (8) @(posedge clk);
			apb(1'b0, 8'h04, 32'h0, 33'h0, '1); // frame closed, counter back to zero
		end
		// mid-run reset must bring the select back to the first word
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0, 33'h0, '1); // select cleared by reset
		apb(1'b0, 8'h04, 32'h0, 33'h0, '1); // no frame after reset
		final_report();
	end
endmodule
